/* File: src/adc_seq_pkg.sv */
// constants, types and register map for the converter sequence controller
// Summary of operation
// [R01] channel code: 0-7 single inputs, 8-11 pairs, 12-15 internal sources
// [R02] inputs not enabled as analog are skipped; pairs need both pins enabled
// [R03] codes below 8 convert inputs zero up to the coded input
// [R04] codes 8-11 run pairs from first up to coded; higher codes convert once
// [R05] end flag sets on each finished conversion, clears on high byte read
// [R06] go bit starts a sequence only with trigger 11 while idle; auto-cleared
// [R07] sequences start from pin edge, previous end, timer compare or go bit
// [R08] trigger codes: 00 pin rise, 01 back-to-back, 10 timer, 11 go bit
// [R09] software changes reference and decimation only while idle; the code takes sequence register writes in any state
// [R10] writing extra register starts one conversion, after any running sequence
// [R11] extra register holds own input, reference, decimation, same encodings
// [R12] with no analog pins, channel field and end flag still update
// [R13] results are two's complement, single-ended positive, differential signed
// [R14] results left aligned: high byte bits 11:4, low byte 3:0 then zeros
// [R15] channel field reads last conversion; codes below 12 read plus one
// [R16] extra conversion loads channel field with its input code unchanged
// [R17] converter clock is system clock divided by six
// [R18] conversion lasts decimation rate plus 16 converter periods
// [R19] settling applies before every conversion
// [R20] decimation 00 is rate 64 seven bits, 01 is rate 128 nine bits
// [R21] interrupt request only when an extra conversion finishes
// [R22] per-channel DMA triggers fire for each sequence or single result
// [R23] any-sample trigger pulses per sequence or single result, never extra
// [R24] two highest DMA trigger lines are shared with the audio serial block
// [R25] end flag stays set if another conversion ends before high byte read
package adc_seq_pkg;
    // register word indices; byte address is four times the index
    localparam logic [7:0]  IDX_CTRL_ONE    = 8'hB4;
    localparam logic [7:0]  IDX_SEQ_CTRL    = 8'hB5;
    localparam logic [7:0]  IDX_EXTRA       = 8'hB6;
    localparam logic [7:0]  IDX_RES_LOW     = 8'hBA;
    localparam logic [7:0]  IDX_RES_HIGH    = 8'hBB;
    localparam logic [7:0]  IDX_PIN_CFG     = 8'hC0;
    localparam logic [7:0]  IDX_NONE        = 8'h00;
    localparam logic [2:0]  HSIZE_WORD      = 3'h2;
    // control register fields
    localparam int          CTL_GO_BIT      = 6;
    localparam int          CTL_TRIG_LSB    = 4;
    localparam logic [1:0]  CTL_RSV_VALUE   = 2'h3;
    localparam logic [1:0]  TRIG_EXT        = 2'h0;
    localparam logic [1:0]  TRIG_FULL       = 2'h1;
    localparam logic [1:0]  TRIG_TIMER      = 2'h2;
    localparam logic [1:0]  TRIG_GO         = 2'h3;
    localparam logic [1:0]  TRIG_RST        = 2'h3;
    // sequence and extra register fields
    localparam int          SC_REF_LSB      = 6;
    localparam int          SC_DIV_LSB      = 4;
    localparam logic [1:0]  DIV_RST         = 2'h1;
    localparam logic [3:0]  CH_LAST_SINGLE  = 4'h7;
    localparam logic [3:0]  CH_FIRST_DIFF   = 4'h8;
    localparam logic [3:0]  CH_LAST_DIFF    = 4'hB;
    localparam logic [3:0]  CH_FIRST_INT    = 4'hC;
    localparam logic [3:0]  DMA_INT_LINE    = 4'h8;
    localparam int          DMA_LINES       = 9;
    // timing
    localparam int          CONV_DIV        = 6;
    localparam logic [2:0]  DIV_LAST        = 3'(CONV_DIV - 1);
    localparam int          SETTLE_PERIODS  = 16;
    localparam int          BASE_RATE       = 64;
    // meaningful result bits per decimation code
    localparam logic [11:0] RES_MASK_0      = 12'hFE0;
    localparam logic [11:0] RES_MASK_1      = 12'hFF8;
    localparam logic [11:0] RES_MASK_2      = 12'hFFC;
    localparam logic [11:0] RES_MASK_3      = 12'hFFF;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SEQ   = 3'b010,
        ST_EXTRA = 3'b100
    } fsm_t;

    typedef struct packed {
        logic [3:0] mux;
        logic [1:0] ref_sel;
        logic [1:0] dec_sel;
        logic       run;
    } analog_ctrl_t;

    typedef struct packed {
        fsm_t       fsm;
        logic [2:0] div_cnt;
        logic [9:0] cnt;
        logic       conv_on;
        logic [3:0] ch;
        logic [1:0] trig;
        logic       go;
        logic       eoc;
        logic [1:0] reference_select;
        logic [1:0] decimation_select;
        logic [3:0] sch_target;
        logic [3:0] sch_rd;
        logic [1:0] eref;
        logic [1:0] ediv;
        logic [3:0] extra_input_select;
        logic       pending;
        logic [7:0] pin_cfg;
        logic [11:0] result;
        logic       ext_prev;
        logic       ap_wr;
        logic [7:0] ap_idx;
        logic [31:0] rdata;
        logic       irq;
        logic [8:0] dma;
        logic       any;
    } state_t;

    localparam state_t STATE_RST = '{fsm: ST_IDLE, trig: TRIG_RST, decimation_select: DIV_RST,
                                     ediv: DIV_RST, default: '0};
endpackage

/* File: src/adc_sequence_control.sv */
// converter sequence control with an AHB-Lite register slave
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module adc_sequence_control (
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic [31:0]                    hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    input  wire logic                      external_trigger_pin,
    input  wire logic                      timer_compare_event,
    input  wire logic [11:0]               filter_result,
    input  wire logic [1:0]                i2s_dma_req,
    output var adc_seq_pkg::analog_ctrl_t  analog_ctrl,
    output logic [8:0]                     dma_trigger,
    output logic                           any_sample_dma_trigger,
    output logic                           adc_irq,
    output logic                           adc_clk_en
);
    import adc_seq_pkg::*;

    state_t     st_reg;
    state_t     st_next;
    logic       ap_take;
    logic [7:0] word_idx;
    logic       rd_result_high_byte;
    logic       tick;
    logic       start_seq;
    logic       seq_last;
    logic       eoc_set;
    logic       advance;
    logic [9:0] seq_len;
    logic [9:0] ext_len;

    function automatic logic [9:0] conv_len(input logic [1:0] dsel);
        conv_len = 10'(SETTLE_PERIODS) + (10'(BASE_RATE) << dsel); // [R18] [R19] [R20]
    endfunction

    function automatic logic [11:0] res_mask(input logic [1:0] dsel);
        case (dsel)
            2'h0:    res_mask = RES_MASK_0; // [R20]
            2'h1:    res_mask = RES_MASK_1;
            2'h2:    res_mask = RES_MASK_2;
            default: res_mask = RES_MASK_3;
        endcase
    endfunction

    function automatic logic ch_enabled(input logic [3:0] ch, input logic [7:0] cfg);
        if (ch <= CH_LAST_SINGLE) begin
            ch_enabled = cfg[ch[2:0]]; // [R02]
        end else if (ch <= CH_LAST_DIFF) begin
            ch_enabled = cfg[{ch[1:0], 1'b0}] & cfg[{ch[1:0], 1'b1}]; // [R02]
        end else begin
            ch_enabled = 1'b1;
        end
    endfunction

    function automatic logic [3:0] first_ch(input logic [3:0] target);
        if (target <= CH_LAST_SINGLE) begin
            first_ch = 4'h0; // [R03]
        end else if (target <= CH_LAST_DIFF) begin
            first_ch = CH_FIRST_DIFF; // [R04]
        end else begin
            first_ch = target; // [R04]
        end
    endfunction

    function automatic logic [3:0] report_ch(input logic [3:0] ch);
        report_ch = (ch < CH_FIRST_INT) ? 4'(ch + 4'h1) : ch; // [R15]
    endfunction

    function automatic logic [3:0] dma_line(input logic [3:0] ch);
        if (ch <= CH_LAST_SINGLE) begin
            dma_line = {1'b0, ch[2:0]};
        end else if (ch <= CH_LAST_DIFF) begin
            dma_line = {2'h0, ch[1:0]};
        end else begin
            dma_line = DMA_INT_LINE;
        end
    endfunction

    function automatic logic [7:0] read_byte(input state_t s, input logic [7:0] idx);
        case (idx)
            IDX_CTRL_ONE: read_byte = {s.eoc, s.go, s.trig, 2'h0, CTL_RSV_VALUE};
            IDX_SEQ_CTRL: read_byte = {s.reference_select, s.decimation_select, s.sch_rd};
            IDX_EXTRA:    read_byte = {s.eref, s.ediv, s.extra_input_select};
            IDX_RES_LOW:  read_byte = {s.result[3:0], 4'h0}; // [R14]
            IDX_RES_HIGH: read_byte = s.result[11:4]; // [R14]
            IDX_PIN_CFG:  read_byte = s.pin_cfg;
            default:      read_byte = 8'h00;
        endcase
    endfunction

    assign ap_take  = hsel & htrans[1] & hready & (hsize == HSIZE_WORD);
    assign word_idx = (haddr[31:10] == 22'h0) ? haddr[9:2] : IDX_NONE;
    assign rd_result_high_byte  = ap_take & ~hwrite & (word_idx == IDX_RES_HIGH);
    assign tick     = (st_reg.div_cnt == DIV_LAST); // [R17]
    assign seq_len  = conv_len(st_reg.decimation_select);
    assign ext_len  = conv_len(st_reg.ediv);
    // the range ends also stop a sequence whose target was rewritten below it
    assign seq_last = (st_reg.ch == st_reg.sch_target) | (st_reg.ch == CH_LAST_SINGLE)
                    | (st_reg.ch >= CH_LAST_DIFF);

    always_comb begin
        case (st_reg.trig)
            TRIG_EXT:   start_seq = external_trigger_pin & ~st_reg.ext_prev; // [R07] [R08]
            TRIG_FULL:  start_seq = 1'b1; // [R07] [R08]
            TRIG_TIMER: start_seq = timer_compare_event; // [R07] [R08]
            default:    start_seq = st_reg.go; // [R06] [R08]
        endcase
    end

    always_comb begin
        st_next          = st_reg;
        eoc_set          = 1'b0;
        advance          = 1'b0;
        st_next.irq      = 1'b0;
        st_next.dma      = '0;
        st_next.any      = 1'b0;
        st_next.ext_prev = external_trigger_pin;
        st_next.div_cnt  = tick ? 3'h0 : 3'(st_reg.div_cnt + 3'h1); // [R17]

        case (st_reg.fsm)
            ST_IDLE: begin
                if (st_reg.pending) begin
                    st_next.fsm     = ST_EXTRA; // [R10]
                    st_next.conv_on = 1'b1;
                    st_next.cnt     = '0;
                end else if (start_seq) begin
                    st_next.fsm     = ST_SEQ;
                    st_next.ch      = first_ch(st_reg.sch_target); // [R03] [R04]
                    st_next.conv_on = 1'b0;
                end
            end
            ST_SEQ: begin
                if (!st_reg.conv_on) begin
                    if (ch_enabled(st_reg.ch, st_reg.pin_cfg)) begin
                        st_next.conv_on = 1'b1; // [R19]
                        st_next.cnt     = '0;
                    end else begin
                        advance = 1'b1; // [R02]
                        if (st_reg.pin_cfg == 8'h00) begin
                            st_next.sch_rd = report_ch(st_reg.ch); // [R12]
                            eoc_set        = 1'b1; // [R12]
                        end
                    end
                end else if (tick) begin
                    if (st_reg.cnt == 10'(seq_len - 10'h1)) begin
                        st_next.result  = filter_result & res_mask(st_reg.decimation_select); // [R13] [R20]
                        st_next.sch_rd  = report_ch(st_reg.ch); // [R15]
                        st_next.dma[dma_line(st_reg.ch)] = 1'b1; // [R22]
                        st_next.any     = 1'b1; // [R23]
                        st_next.conv_on = 1'b0;
                        eoc_set         = 1'b1; // [R05]
                        advance         = 1'b1;
                    end else begin
                        st_next.cnt = 10'(st_reg.cnt + 10'h1); // [R18]
                    end
                end
                if (advance) begin
                    if (seq_last) begin
                        st_next.fsm = ST_IDLE;
                        st_next.go  = 1'b0; // [R06]
                    end else begin
                        st_next.ch = 4'(st_reg.ch + 4'h1); // [R03] [R04]
                    end
                end
            end
            ST_EXTRA: begin
                if (tick) begin
                    if (st_reg.cnt == 10'(ext_len - 10'h1)) begin
                        st_next.result  = filter_result & res_mask(st_reg.ediv); // [R11]
                        st_next.sch_rd  = st_reg.extra_input_select; // [R16]
                        st_next.irq     = 1'b1; // [R21]
                        st_next.pending = 1'b0;
                        st_next.conv_on = 1'b0;
                        st_next.fsm     = ST_IDLE;
                        eoc_set         = 1'b1; // [R05]
                    end else begin
                        st_next.cnt = 10'(st_reg.cnt + 10'h1); // [R18]
                    end
                end
            end
            default: begin
                st_next.fsm     = ST_IDLE;
                st_next.conv_on = 1'b0;
            end
        endcase

        // bus address phase: capture write target, latch read data
        st_next.ap_wr = ap_take & hwrite;
        if (ap_take) begin
            st_next.ap_idx = word_idx;
        end
        if (ap_take && !hwrite) begin
            st_next.rdata = {24'h0, read_byte(st_reg, word_idx)};
        end

        // bus data phase: register writes
        if (st_reg.ap_wr) begin
            case (st_reg.ap_idx)
                IDX_CTRL_ONE: begin
                    st_next.trig = hwdata[CTL_TRIG_LSB +: 2];
                    if (hwdata[CTL_GO_BIT] && hwdata[CTL_TRIG_LSB +: 2] == TRIG_GO
                        && st_reg.fsm == ST_IDLE) begin
                        st_next.go = 1'b1; // [R06]
                    end
                end
                IDX_SEQ_CTRL: begin
                    st_next.reference_select       = hwdata[SC_REF_LSB +: 2];
                    st_next.decimation_select       = hwdata[SC_DIV_LSB +: 2];
                    st_next.sch_target = hwdata[3:0]; // [R01]
                    st_next.sch_rd     = hwdata[3:0];
                end
                IDX_EXTRA: begin
                    st_next.eref    = hwdata[SC_REF_LSB +: 2]; // [R11]
                    st_next.ediv    = hwdata[SC_DIV_LSB +: 2]; // [R11]
                    st_next.extra_input_select     = hwdata[3:0]; // [R11]
                    st_next.pending = 1'b1; // [R10]
                end
                IDX_PIN_CFG: begin
                    st_next.pin_cfg = hwdata[7:0];
                end
                default: begin
                    st_next.pin_cfg = st_reg.pin_cfg;
                end
            endcase
        end

        // a completion in the cycle of the high byte read keeps the flag set
        st_next.eoc = (st_reg.eoc & ~rd_result_high_byte) | eoc_set; // [R05] [R25]
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= STATE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hrdata                 = st_reg.rdata;
    assign hreadyout              = 1'b1;
    assign hresp                  = 1'b0;
    assign adc_clk_en             = tick;
    assign adc_irq                = st_reg.irq;
    assign any_sample_dma_trigger = st_reg.any;
    assign dma_trigger            = st_reg.dma | {i2s_dma_req, 7'h00}; // [R24]

    always_comb begin
        analog_ctrl.run = st_reg.conv_on;
        if (st_reg.fsm == ST_EXTRA) begin
            analog_ctrl.mux     = st_reg.extra_input_select; // [R11]
            analog_ctrl.ref_sel = st_reg.eref;
            analog_ctrl.dec_sel = st_reg.ediv;
        end else begin
            analog_ctrl.mux     = st_reg.ch; // [R01]
            analog_ctrl.ref_sel = st_reg.reference_select;
            analog_ctrl.dec_sel = st_reg.decimation_select;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_eoc_sticky;
        st_reg.eoc && !rd_result_high_byte |=> st_reg.eoc;
    endproperty
    a_eoc_sticky: assert property (p_eoc_sticky) // [R25]
        else $error("end flag dropped without a high byte read");

    property p_eoc_clear;
        rd_result_high_byte && !eoc_set |=> !st_reg.eoc;
    endproperty
    a_eoc_clear: assert property (p_eoc_clear) // [R05]
        else $error("end flag not cleared by high byte read");

    property p_eoc_set;
        eoc_set |=> st_reg.eoc;
    endproperty
    a_eoc_set: assert property (p_eoc_set) // [R05]
        else $error("end flag not set after a conversion");

    property p_tick_period;
        tick |=> !tick [*5] ##1 tick;
    endproperty
    a_tick_period: assert property (p_tick_period) // [R17]
        else $error("converter clock enable is not one in six");

    property p_irq_clean;
        st_reg.irq |-> (st_reg.dma == '0) && !st_reg.any && $past(st_reg.fsm) == ST_EXTRA;
    endproperty
    a_irq_clean: assert property (p_irq_clean) // [R21]
        else $error("interrupt outside extra completion or with a trigger");

    property p_extra_sch;
        st_reg.irq && !$past(st_reg.ap_wr) |-> st_reg.sch_rd == st_reg.extra_input_select;
    endproperty
    a_extra_sch: assert property (p_extra_sch) // [R16]
        else $error("channel field not loaded with extra input code");

    property p_any_dma;
        st_reg.any |-> $onehot(st_reg.dma) && !st_reg.irq;
    endproperty
    a_any_dma: assert property (p_any_dma) // [R23]
        else $error("any-sample trigger without exactly one channel trigger");

    property p_go_start;
        st_reg.fsm == ST_IDLE && !st_reg.pending && st_reg.go && st_reg.trig == TRIG_GO
            |=> st_reg.fsm == ST_SEQ;
    endproperty
    a_go_start: assert property (p_go_start) // [R06]
        else $error("go bit did not start a sequence");

    property p_ext_start;
        st_reg.fsm == ST_IDLE && !st_reg.pending && st_reg.trig == TRIG_EXT
            && external_trigger_pin && !st_reg.ext_prev |=> st_reg.fsm == ST_SEQ;
    endproperty
    a_ext_start: assert property (p_ext_start) // [R07]
        else $error("pin rising edge did not start a sequence");

    property p_go_clear;
        st_reg.fsm == ST_SEQ ##1 st_reg.fsm == ST_IDLE |-> !st_reg.go;
    endproperty
    a_go_clear: assert property (p_go_clear) // [R06]
        else $error("go bit still set after sequence end");

    property p_extra_wait;
        st_reg.fsm == ST_IDLE && st_reg.pending |=> st_reg.fsm == ST_EXTRA;
    endproperty
    a_extra_wait: assert property (p_extra_wait) // [R10]
        else $error("pending extra conversion not started");

    c_seq_done: cover property (st_reg.fsm == ST_SEQ && st_reg.go ##1 st_reg.fsm == ST_IDLE);
    c_extra_done: cover property (st_reg.irq);
    c_phantom: cover property (st_reg.fsm == ST_SEQ && st_reg.pin_cfg == 8'h00 && eoc_set);
    c_full_speed: cover property (st_reg.trig == TRIG_FULL && st_reg.any ##[1:1000] st_reg.any);
endmodule
`default_nettype wire

/* File: dv/sample_collector.sv */
// far-side model: filter sample source and dma/cpu event counter
`timescale 1ns/1ps
`default_nettype none
module sample_collector (
    input  wire logic        hclk,
    input  wire logic        clear,
    input  wire logic [8:0]  dma_trigger,
    input  wire logic        any_sample_dma_trigger,
    input  wire logic        adc_irq,
    input  wire logic [11:0] sample,
    output logic [11:0]      filter_result,
    output logic [8:0]       lines,
    output int               any_cnt,
    output int               irq_cnt
);
    assign filter_result = sample;
    always_ff @(posedge hclk) begin
        if (clear) begin
            lines <= '0;
            any_cnt <= 0;
            irq_cnt <= 0;
        end else begin
            lines <= lines | dma_trigger;
            any_cnt <= any_cnt + 32'(any_sample_dma_trigger);
            irq_cnt <= irq_cnt + 32'(adc_irq);
        end
    end
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for the converter sequence controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import adc_seq_pkg::*;
    localparam logic [11:0] SAMPLE = 12'h5AC;
    logic         hclk, hresetn, hsel, hwrite, hready, hresp, ext_pin, timer_evt;
    logic         any_trig, irq, clk_en, clear;
    logic [31:0]  haddr, hwdata, hrdata;
    logic [1:0]   htrans, i2s_req;
    logic [2:0]   hsize;
    logic [11:0]  filt;
    logic [8:0]   dma, lines;
    analog_ctrl_t actrl;
    int           any_cnt, irq_cnt, failures, checks;

    adc_sequence_control i_adc_sequence_control (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .external_trigger_pin(ext_pin),
        .timer_compare_event(timer_evt), .filter_result(filt), .i2s_dma_req(i2s_req),
        .analog_ctrl(actrl), .dma_trigger(dma), .any_sample_dma_trigger(any_trig),
        .adc_irq(irq), .adc_clk_en(clk_en));
    sample_collector i_sample_collector (
        .hclk(hclk), .clear(clear), .dma_trigger(dma), .any_sample_dma_trigger(any_trig),
        .adc_irq(irq), .sample(SAMPLE), .filter_result(filt), .lines(lines),
        .any_cnt(any_cnt), .irq_cnt(irq_cnt));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic timeout(input int n, input int lim);
        if (n >= lim) begin
            failures++;
            complete_run();
        end
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        timeout(n, 50);
    endtask
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, idx, 2'h0};
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] rd;
        bus(1'b1, idx, {24'h0, d}, rd);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
        logic [31:0] rd;
        bus(1'b0, idx, 32'h0, rd);
        chk(rd, {24'h0, e});
    endtask
    // re-read a register until its masked value matches, within a bound
    task automatic poll(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e);
        logic [31:0] rd;
        int n;
        n = 0;
        do begin
            bus(1'b0, idx, 32'h0, rd);
            n++;
        end while ((rd[7:0] & m) !== e && n < 1500);
        chk({24'h0, rd[7:0] & m}, {24'h0, e});
        timeout(n, 1500);
    endtask
    task automatic wait_cnt(input logic sel_irq, input int k, output int n);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while ((sel_irq ? irq_cnt : any_cnt) < k && n < 2500);
        timeout(n, 2500);
    endtask
    task automatic next_en(output int n);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (clk_en !== 1'b1 && n < 20);
        timeout(n, 20);
    endtask
    task automatic clear_cnt();
        clear <= 1'b1;
        @(posedge hclk);
        clear <= 1'b0;
    endtask

    task automatic t_reset();
        int n;
        rd_chk(IDX_CTRL_ONE, 8'h33);
        rd_chk(IDX_SEQ_CTRL, 8'h10);
        rd_chk(IDX_EXTRA, 8'h10);
        wr(IDX_RES_LOW, 8'hFF);
        rd_chk(IDX_RES_LOW, 8'h00);
        wr(8'h50, 8'hFF);
        rd_chk(8'h50, 8'h00);
        next_en(n);
        next_en(n);
        chk(32'(n), CONV_DIV);
        i2s_req <= 2'h3;
        @(posedge hclk);
        chk(32'(dma[8:7]), 32'h3);
        chk(32'(hresp), 32'h0);
        i2s_req <= 2'h0;
    endtask
    task automatic t_timing();
        int n;
        logic [11:0] r;
        for (int d = 0; d < 2; d++) begin
            r = SAMPLE & (d == 0 ? RES_MASK_0 : RES_MASK_1);
            wr(IDX_PIN_CFG, 8'h01);
            wr(IDX_SEQ_CTRL, {2'h0, 2'(d), 4'h0});
            clear_cnt();
            wr(IDX_CTRL_ONE, 8'h73);
            wait_cnt(1'b0, 1, n);
            n = n - (SETTLE_PERIODS + (BASE_RATE << d)) * CONV_DIV;
            chk(32'(n >= -1 && n <= 4), 32'h1);
            poll(IDX_CTRL_ONE, 8'h40, 8'h00);
            rd_chk(IDX_RES_LOW, {r[3:0], 4'h0});
            rd_chk(IDX_RES_HIGH, r[11:4]);
            rd_chk(IDX_CTRL_ONE, 8'h33);
        end
    endtask
    task automatic run_seq(input logic [7:0] pins, input logic [3:0] code,
                           input logic [8:0] ln, input logic [7:0] an, input logic [3:0] last);
        logic [31:0] rd;
        bus(1'b0, IDX_RES_HIGH, 32'h0, rd);
        wr(IDX_PIN_CFG, pins);
        wr(IDX_SEQ_CTRL, {4'h0, code});
        clear_cnt();
        wr(IDX_CTRL_ONE, 8'h73);
        poll(IDX_CTRL_ONE, 8'h40, 8'h00);
        chk({lines, 8'(any_cnt), 8'(irq_cnt)}, {ln, an, 8'h0});
        rd_chk(IDX_SEQ_CTRL, {4'h0, last});
        rd_chk(IDX_CTRL_ONE, 8'hB3);
    endtask
    task automatic t_extra();
        int n;
        wr(IDX_PIN_CFG, 8'h21);
        wr(IDX_SEQ_CTRL, 8'h00);
        clear_cnt();
        wr(IDX_CTRL_ONE, 8'h73);
        wr(IDX_EXTRA, 8'h05);
        wait_cnt(1'b0, 1, n);
        repeat (3) @(posedge hclk);
        chk(32'({actrl.mux, actrl.run}), 32'h0B);
        wait_cnt(1'b1, 1, n);
        chk({lines, 8'(any_cnt)}, {9'h001, 8'h1});
        rd_chk(IDX_SEQ_CTRL, 8'h05);
    endtask
    task automatic t_trig();
        logic [31:0] rd;
        wr(IDX_PIN_CFG, 8'h00);
        bus(1'b0, IDX_RES_HIGH, 32'h0, rd);
        wr(IDX_CTRL_ONE, 8'h03);
        wr(IDX_SEQ_CTRL, 8'h01);
        wr(IDX_CTRL_ONE, 8'h43);
        rd_chk(IDX_CTRL_ONE, 8'h03);
        ext_pin <= 1'b1;
        poll(IDX_SEQ_CTRL, 8'hFF, 8'h02);
        ext_pin <= 1'b0;
        wr(IDX_CTRL_ONE, 8'h23);
        wr(IDX_SEQ_CTRL, 8'h00);
        timer_evt <= 1'b1;
        @(posedge hclk);
        timer_evt <= 1'b0;
        poll(IDX_SEQ_CTRL, 8'hFF, 8'h01);
        wr(IDX_CTRL_ONE, 8'h13);
        wr(IDX_SEQ_CTRL, 8'h02);
        poll(IDX_SEQ_CTRL, 8'hFF, 8'h03);
        wr(IDX_CTRL_ONE, 8'h33);
    endtask

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        {hresetn, htrans, haddr, hwrite, hwdata, ext_pin, timer_evt, i2s_req} = '0;
        {hsel, clear, hsize} = {2'b11, HSIZE_WORD};
        {failures, checks} = '0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        clear <= 1'b0;
        t_reset();
        t_timing();
        run_seq(8'h0F, 4'h9, 9'h003, 8'h2, 4'hA);
        run_seq(8'h07, 4'h9, 9'h001, 8'h1, 4'h9);
        run_seq(8'h05, 4'h2, 9'h005, 8'h2, 4'h3);
        run_seq(8'h00, 4'hD, 9'h100, 8'h1, 4'hD);
        run_seq(8'h00, 4'h3, 9'h000, 8'h0, 4'h4);
        t_extra();
        t_trig();
        complete_run();
    end
endmodule
`default_nettype wire
